// *** mis_core_model.sv ***
// Behavioural core: makes one boundary pulse per four-clock instruction cycle and a running PC.
// Assumes the sequencer answers with a one-cycle acknowledge carrying the vector.
`timescale 1ns/1ps
module mis_core_model (
  input wire clock,
  input wire srst,
  input wire irq_ack,
  input wire [11:0] irq_vector,
  output reg phase_two_pulse,
  output reg [11:0] program_counter
);
  reg [1:0] phase; // Position inside the instruction cycle.
  // status saving is software's job; this core pushes nothing beyond the PC.
  always @(posedge clock) begin
    if (srst) begin
      phase <= 2'h0;
      phase_two_pulse <= 1'b0;
      program_counter <= 12'h100;
    end else begin
      phase <= phase + 2'h1;
      phase_two_pulse <= (phase == 2'h3);
      // The vector wins over the step, as the core branches instead of fetching on.
      if (irq_ack) program_counter <= irq_vector;
      else if (phase_two_pulse) program_counter <= program_counter + 12'h001;
    end
  end
endmodule

// *** mis_map.vh ***
// Register offsets, field positions, vectors and reset values of the interrupt sequencer.
// Included by the sequencer module; holds definitions only.
`ifndef MIS_MAP_VH
`define MIS_MAP_VH
// Register offsets on the data-memory style register port.
`define MIS_ADDR_CTRL_LOW 8'h0B
`define MIS_ADDR_CTRL_HIGH 8'h1E
`define MIS_ADDR_IRQ_STATUS 8'h24
`define MIS_ADDR_IRQ_MASK 8'h25
// Field positions in irq_control_low.
`define MIS_LOW_EMI 0
`define MIS_LOW_EN_EXT0 1
`define MIS_LOW_EN_EXT1 2
`define MIS_LOW_EN_TMR 3
`define MIS_LOW_FLAG_EXT0 4
`define MIS_LOW_FLAG_EXT1 5
`define MIS_LOW_FLAG_TMR 6
// Field positions in irq_control_high.
`define MIS_HIGH_EN_TB 0
`define MIS_HIGH_EN_ADC 1
`define MIS_HIGH_EN_RTC 2
`define MIS_HIGH_FLAG_TB 4
`define MIS_HIGH_FLAG_ADC 5
`define MIS_HIGH_FLAG_RTC 6
// Fixed vector addresses, 12-bit program counter.
`define MIS_VEC_EXT0 12'h004
`define MIS_VEC_EXT1 12'h008
`define MIS_VEC_TMR 12'h00C
`define MIS_VEC_TB 12'h010
`define MIS_VEC_ADC 12'h014
`define MIS_VEC_RTC 12'h018
// Reset values.
`define MIS_RST_CTRL 8'h00
`define MIS_RST_MASK 8'h00
// Stack depth and number of sources.
`define MIS_STACK_DEPTH 8
`define MIS_NUM_SRC 6
`endif

// *** mis_seq_properties.sv ***
// Checker for the interrupt sequencer: acknowledge, stack level, wake and register port timing.
// Sees only the sequencer's ports and is bound to every sequencer instance.
`timescale 1ns/1ps
module mis_seq_properties #(
  parameter PC_WIDTH = 12
) (
  input wire clock,
  input wire srst,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire timer_overflow,
  input wire timebase_timeout,
  input wire adc_done,
  input wire rtc_timeout,
  input wire phase_two_pulse,
  input wire [PC_WIDTH-1:0] program_counter,
  input wire call_instr,
  input wire sub_return_instr,
  input wire irq_return_instr,
  input wire irq_ack,
  input wire [PC_WIDTH-1:0] irq_vector,
  input wire [PC_WIDTH-1:0] push_value,
  input wire [3:0] stack_level_pointer,
  input wire stack_full,
  input wire wake_request
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_ack_single_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge lasted more than one cycle");
  a_ack_at_boundary: assert property (irq_ack |-> $past(phase_two_pulse) && !$past(stack_full))
    else $error("acknowledge without boundary or with full stack");
  a_push_only_pc: assert property (irq_ack |-> push_value == $past(program_counter))
    else $error("pushed value is not the program counter");
  a_ack_stack_grows: assert property (irq_ack && !$past(call_instr) |->
    stack_level_pointer == $past(stack_level_pointer) + 4'h1)
    else $error("stack level did not grow on acknowledge");
  a_vector_table: assert property (irq_ack |-> irq_vector inside {12'h004, 12'h008, 12'h00C,
    12'h010, 12'h014, 12'h018})
    else $error("vector outside the fixed table");
  a_full_no_ack: assert property (phase_two_pulse && stack_full |=> !irq_ack)
    else $error("acknowledge taken with full stack");
  a_event_wakes: assert property (timer_overflow || timebase_timeout || adc_done || rtc_timeout
    |=> wake_request)
    else $error("event did not raise wake request");
  a_read_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_return_pops: assert property ((sub_return_instr || irq_return_instr) && !call_instr &&
    !phase_two_pulse && stack_level_pointer != 4'h0 |=>
    stack_level_pointer == $past(stack_level_pointer) - 4'h1)
    else $error("return did not lower the stack level");
  c_ack: cover property (irq_ack);
  c_full_wait: cover property (phase_two_pulse && stack_full);
  c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule
bind mis_sequencer mis_seq_properties #(.PC_WIDTH(PC_WIDTH)) chk_u (.*);

// *** mis_sequencer.v ***
// Interrupt sequencer for an 8-bit microcontroller core: flags, enables, priority, vector, stack push.
// Assumes the core gives a one-cycle phase_two_pulse per instruction cycle and executes the
// push, vector load and returns; event inputs other than the pins are synchronous pulses.
//
// Overview of operation
// [RULE1] Six sources: two pins, timer, timebase, ADC, RTC.
// [RULE2] Servicing any interrupt clears the master enable.
// [RULE3] Flags still set while master enable clear.
// [RULE4] Re-enabling inside routine allows nested acknowledge.
// [RULE5] Full stack withholds acknowledge until return.
// [RULE6] Every source wakes the halted device.
// [RULE7] Push program counter only, then load vector.
// [RULE8] Pin edges set flag bits 4/5 low.
// [RULE9] Pins vector 004H/008H, clearing flag and enable; the code clears only the flag, and the enable stays set.
// [RULE10] Timer flag bit 6 low, vector 00CH.
// [RULE11] Timebase flag bit 4 high, vector 010H.
// [RULE12] ADC flag bit 5 high, vector 014H.
// [RULE13] RTC flag bit 6 high, vector 018H.
// [RULE14] Interrupt return sets enable; subroutine return not.
// [RULE15] Software saves status flags itself.
// [RULE16] Fixed priority: ext0, ext1, timer, timebase, ADC, RTC.
// [RULE17] Sample once per instruction cycle at pulse.
// [RULE18] Flags stay until serviced or cleared; 1=enabled.
// [RULE19] One acknowledge per boundary, all enables required.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "mis_map.vh"

module mis_sequencer #(
  parameter PC_WIDTH = 12,
  parameter STACK_DEPTH = `MIS_STACK_DEPTH
) (
  input wire clock,
  input wire srst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Raw pins, asynchronous to the clock.
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  // Edge selection per pin: bit 0 falling, bit 1 rising.
  input wire [1:0] pin_a_edge_sel,
  input wire [1:0] pin_b_edge_sel,
  // Internal event pulses, one cycle each.
  input wire timer_overflow,
  input wire timebase_timeout,
  input wire adc_done,
  input wire rtc_timeout,
  // Core interface.
  input wire phase_two_pulse,
  input wire [PC_WIDTH-1:0] program_counter,
  input wire call_instr,
  input wire sub_return_instr,
  input wire irq_return_instr,
  output reg irq_ack,
  output reg [PC_WIDTH-1:0] irq_vector,
  output reg [PC_WIDTH-1:0] push_value,
  output reg [3:0] stack_level_pointer,
  output wire stack_full,
  output wire wake_request,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  reg [1:0] sync_a; // Two-stage synchroniser for pin a.
  reg [1:0] sync_b; // Two-stage synchroniser for pin b.
  reg last_a; // Previous synchronised level of pin a.
  reg last_b; // Previous synchronised level of pin b.

  // Only the second stage is looked at, so metastability never reaches the edge logic.
  always @(posedge clock) begin
    if (srst) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      last_a <= 1'b0;
      last_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], ext_irq_pin_a};
      sync_b <= {sync_b[0], ext_irq_pin_b};
      last_a <= sync_a[1];
      last_b <= sync_b[1];
    end
  end

  // Edge filter: chosen falling and/or rising transitions count.
  function edge_hit;
    input now_level;
    input old_level;
    input [1:0] sel;
    begin
      edge_hit = (sel[0] & old_level & ~now_level) | (sel[1] & ~old_level & now_level);
    end
  endfunction

  wire ev_ext0 = edge_hit(sync_a[1], last_a, pin_a_edge_sel); // Pin a event.
  wire ev_ext1 = edge_hit(sync_b[1], last_b, pin_b_edge_sel); // Pin b event.

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  reg master_irq_enable; // Global enable.
  reg [5:0] src_enable; // Per-source enables, priority order.
  reg [5:0] src_flag; // Request flags, priority order.
  reg [5:0] irq_status; // Sticky event copy for the interrupt output.
  reg [5:0] irq_mask; // Mask for the interrupt output.

  // [RULE1] six event sources
  wire [5:0] events = {rtc_timeout, adc_done, timebase_timeout, timer_overflow, ev_ext1, ev_ext0};

  // Requests eligible for acknowledge, before the stack check.
  wire [5:0] eligible = src_flag & src_enable & {6{master_irq_enable}};

  // [RULE5] full stack blocks
  assign stack_full = (stack_level_pointer == STACK_DEPTH[3:0]);

  // Priority picker: lowest index wins, one-hot result.
  function [5:0] pick_first;
    input [5:0] req;
    begin
      // [RULE16] fixed priority order
      pick_first = req & ~(req - 6'h01) & 6'h3F;
    end
  endfunction

  // Vector lookup for a one-hot grant.
  function [11:0] vector_of;
    input [5:0] grant;
    begin
      case (grant)
        // [RULE9] pin vectors
        6'h01: vector_of = `MIS_VEC_EXT0;
        6'h02: vector_of = `MIS_VEC_EXT1;
        // [RULE10] timer vector
        6'h04: vector_of = `MIS_VEC_TMR;
        // [RULE11] timebase vector
        6'h08: vector_of = `MIS_VEC_TB;
        // [RULE12] ADC vector
        6'h10: vector_of = `MIS_VEC_ADC;
        // [RULE13] RTC vector
        6'h20: vector_of = `MIS_VEC_RTC;
        default: vector_of = 12'h000;
      endcase
    end
  endfunction

  // [RULE19] one acknowledge, all enables
  wire take = phase_two_pulse & ~stack_full & (|eligible);
  wire [5:0] grant = take ? pick_first(eligible) : 6'h00;

  wire wr_low = reg_write & (reg_addr == `MIS_ADDR_CTRL_LOW); // Write to low control.
  wire wr_high = reg_write & (reg_addr == `MIS_ADDR_CTRL_HIGH); // Write to high control.
  wire wr_mask = reg_write & (reg_addr == `MIS_ADDR_IRQ_MASK); // Write to mask.
  wire rd_status = reg_read & (reg_addr == `MIS_ADDR_IRQ_STATUS); // Status read clears.

  // Software view of flags written this cycle; flags not addressed keep their value.
  reg [5:0] next_flag;
  reg [5:0] next_enable;
  reg next_master;

  // Register writes first, then service clears, then new events, so an event always wins.
  always @* begin
    next_flag = src_flag;
    next_enable = src_enable;
    next_master = master_irq_enable;
    if (wr_low) begin
      next_master = reg_wdata[`MIS_LOW_EMI];
      next_enable[2:0] = {reg_wdata[`MIS_LOW_EN_TMR], reg_wdata[`MIS_LOW_EN_EXT1], reg_wdata[`MIS_LOW_EN_EXT0]};
      next_flag[2:0] = {reg_wdata[`MIS_LOW_FLAG_TMR], reg_wdata[`MIS_LOW_FLAG_EXT1], reg_wdata[`MIS_LOW_FLAG_EXT0]};
    end
    if (wr_high) begin
      next_enable[5:3] = {reg_wdata[`MIS_HIGH_EN_RTC], reg_wdata[`MIS_HIGH_EN_ADC], reg_wdata[`MIS_HIGH_EN_TB]};
      next_flag[5:3] = {reg_wdata[`MIS_HIGH_FLAG_RTC], reg_wdata[`MIS_HIGH_FLAG_ADC], reg_wdata[`MIS_HIGH_FLAG_TB]};
    end
    // [RULE14] return restores enable
    if (irq_return_instr) begin
      next_master = 1'b1;
    end
    // [RULE2] entry clears enable
    if (take) begin
      next_master = 1'b0;
    end
    // [RULE18] clear on service
    next_flag = next_flag & ~grant;
    // [RULE3] flags always recorded
    // [RULE8] pin edges set flags
    next_flag = next_flag | events;
  end

  // [RULE4] re-enable allows nesting
  always @(posedge clock) begin
    if (srst) begin
      master_irq_enable <= 1'b0;
      src_enable <= 6'h00;
      src_flag <= 6'h00;
    end else begin
      master_irq_enable <= next_master;
      src_enable <= next_enable;
      src_flag <= next_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge, vector and stack level.

  // [RULE17] sample at phase pulse
  always @(posedge clock) begin
    if (srst) begin
      irq_ack <= 1'b0;
      irq_vector <= {PC_WIDTH{1'b0}};
      push_value <= {PC_WIDTH{1'b0}};
      stack_level_pointer <= 4'h0;
    end else begin
      irq_ack <= take;
      if (take) begin
        // [RULE7] push PC, load vector
        push_value <= program_counter;
        irq_vector <= vector_of(grant);
      end
      // Calls past a full stack wrap the oldest entry; the level saturates.
      if ((take | call_instr) & ~stack_full) begin
        stack_level_pointer <= stack_level_pointer + 4'h1;
      end else if ((sub_return_instr | irq_return_instr) & (stack_level_pointer != 4'h0)) begin
        stack_level_pointer <= stack_level_pointer - 4'h1;
      end
    end
  end

  // [RULE6] any flag wakes
  assign wake_request = |src_flag;

  // [RULE15] status not saved here
  // Nothing beyond the program counter is pushed; software owns the rest.

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, mask and interrupt output.

  // A set in the same cycle as the clearing read wins.
  always @(posedge clock) begin
    if (srst) begin
      irq_status <= 6'h00;
      irq_mask <= 6'h00;
    end else begin
      irq_status <= (rd_status ? 6'h00 : irq_status) | events;
      if (wr_mask) begin
        irq_mask <= reg_wdata[5:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read mux; unmapped addresses read zero, bit 7 of both control registers and bit 3 of the high one read zero.
  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `MIS_ADDR_CTRL_LOW: reg_rdata <= {1'b0, src_flag[2:0], src_enable[2:0], master_irq_enable};
        `MIS_ADDR_CTRL_HIGH: reg_rdata <= {1'b0, src_flag[5:3], 1'b0, src_enable[5:3]};
        `MIS_ADDR_IRQ_STATUS: reg_rdata <= {2'h0, irq_status};
        `MIS_ADDR_IRQ_MASK: reg_rdata <= {2'h0, irq_mask};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// *** mis_sequencer_test.sv ***
// Self-checking bench for the interrupt sequencer with a queue model of pending sources.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module mis_sequencer_test;
  logic clock = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic ext_irq_pin_a = 1'b0, ext_irq_pin_b = 1'b0;
  logic [1:0] pin_a_edge_sel = 2'h3, pin_b_edge_sel = 2'h3;
  logic [3:0] evt = 4'h0; // Timer, timebase, ADC and RTC event pulses.
  logic [2:0] ctl = 3'h0; // Call, subroutine return and interrupt return pulses.
  logic phase_two_pulse, irq_ack, stack_full, wake_request, irq;
  logic [11:0] program_counter, irq_vector, push_value;
  logic [3:0] stack_level_pointer;
  wire timer_overflow = evt[0], timebase_timeout = evt[1], adc_done = evt[2], rtc_timeout = evt[3];
  wire call_instr = ctl[0], sub_return_instr = ctl[1], irq_return_instr = ctl[2];
  int fails = 0, checks = 0, cycles = 0, src, msk, k, fl;
  int q[$];
  mis_sequencer dut_u (.*);
  mis_core_model core_u (.*);
  initial forever #5 clock = ~clock;
  task end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock) reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clock) reg_read <= 1'b0;
    #1 chk(what, {4'h0, exp}, {4'h0, reg_rdata});
  endtask
  task ev(input int i);
    @(posedge clock) evt <= 4'(1 << i);
    @(posedge clock) evt <= 4'h0;
  endtask
  task op(input logic [2:0] v);
    @(posedge clock) ctl <= v;
    @(posedge clock) ctl <= 3'h0;
  endtask
  // Waits a bounded time for the acknowledge and compares its vector.
  task wait_ack(input logic [11:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (irq_ack !== 1'b1 && n < 40);
    chk("irq_vector", exp, (irq_ack === 1'b1) ? irq_vector : 12'hFFF);
  endtask
  // A hang is cut short and counted as a mismatch.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    src = $urandom(4);
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(8'h0B, 8'h00, "ctrl_low reset");
    rd(8'h30, 8'h00, "unmapped read");
    wr(8'h0B, 8'h0E);
    wr(8'h1E, 8'h07);
    rd(8'h1E, 8'h07, "ctrl_high enables");
    $display("test registers done");
    // All six sources flag with the master enable off, then are served in priority order.
    @(posedge clock) {ext_irq_pin_a, ext_irq_pin_b} <= 2'h3;
    for (int i = 0; i < 4; i++) ev(i);
    repeat (8) @(posedge clock);
    rd(8'h0B, 8'h7E, "flags low held");
    rd(8'h1E, 8'h77, "flags high held");
    q = {0, 1, 2, 3, 4, 5};
    wr(8'h0B, 8'h7F);
    while (q.size() > 0) begin
      k = q.pop_front();
      wait_ack(12'(4 * k + 4));
      fl = 0;
      foreach (q[j]) fl |= 1 << q[j];
      rd(8'h0B, {1'b0, fl[2:0], 4'hE}, "ctrl_low after ack");
      rd(8'h1E, {1'b0, fl[5:3], 4'h7}, "ctrl_high after ack");
      op(3'b100);
    end
    $display("test priority done");
    // Random internal events against a random mask; the status read clears the line.
    wr(8'h0B, 8'h00);
    wr(8'h1E, 8'h00);
    // Every source fired once above, so the sticky status must be emptied before the random rounds.
    rd(8'h24, 8'h3F, "status sticky");
    repeat (6) begin
      src = 2 + $urandom % 4;
      msk = $urandom % 2;
      wr(8'h25, 8'(msk << src));
      ev(src - 2);
      @(posedge clock);
      #1 chk("irq", 12'(msk), {11'h0, irq});
      rd(8'h24, 8'(1 << src), "status");
      chk("irq cleared", 12'h000, {11'h0, irq});
    end
    $display("test status done");
    // A full stack holds the timer request back until a return frees a level.
    wr(8'h0B, 8'h09);
    repeat (8) op(3'b001);
    ev(0);
    repeat (12) @(posedge clock);
    rd(8'h0B, 8'h49, "held while full");
    chk("stack level", 12'h008, {8'h0, stack_level_pointer});
    op(3'b010);
    wait_ack(12'h00C);
    op(3'b010);
    rd(8'h0B, 8'h08, "plain return keeps master off");
    op(3'b100);
    rd(8'h0B, 8'h09, "interrupt return sets master");
    $display("test stack done");
    end_sim();
  end
endmodule
